// ==== core/anc_tc_inserter.v ====
/*
 * output stage of a serial video test generator: timecode selection with
 * offset, component gating, edge filter, delay test cycle, edh enable and a
 * user ancillary packet inserter, all set over an avalon-mm slave.
 * assumes the upstream raster marks sav, line, field, audio and crc words,
 * and supplies the legal line and sample ranges of the current format.
 */
// Contract
// - timecode comes from program counter or time of day, the latter only if fitted
// - a configurable offset is added to the selected timecode source
// - drop frame counting allowed only at the two fractional rates
// - linear timecode packets inserted only while their enable is set
// - interval timecode packets inserted only while their enable is set
// - three component enables; a disabled component is blanked in the output
// - edge filter low-passes transitions when enabled and filter fitted
// - delay test: one second as configured, four seconds black and muted
// - edh packets only when enabled and format is standard definition
// - any non-standard setting raises the asterisk status marker
// - user packet may overwrite anything except embedded audio and crc
// - packet order: did, sdid, count, user words, checksum
// - count field gives the number of user words that follow
// - user word store is indexed 0 to 254
// - output modes off, continuous, single shot of one packet per trigger
// - auto parity sends 8-bit payload with generated upper bits; manual sends 10
// - all 10 entered bits are always kept in storage
// - did, sdid and count accept 8-bit or 10-bit values per parity mode
// - checksum is computed when auto is on, else the stored value is sent
// - out-of-range line or sample offset suppresses the packet
// - sample offset counts from sav; header word placed there
`timescale 1ns/1ps
`include "anc_tc_map.vh"

module anc_tc_inserter #(
    parameter ON_CYCLES  = `ON_CYCLES,
    parameter OFF_CYCLES = `OFF_CYCLES
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [31:0] prog_tc,
    input  wire [31:0] tod_tc,
    input  wire        gps_fitted,
    input  wire        fmt_fractional,
    input  wire        fmt_sd,
    input  wire        filter_fitted,
    input  wire [10:0] line_max,
    input  wire [11:0] sample_max,
    input  wire        vid_in_valid,
    input  wire        vid_in_sav,
    input  wire        vid_in_active,
    input  wire        vid_in_field2,
    input  wire [10:0] vid_in_line,
    input  wire        vid_in_protect,
    input  wire [9:0]  vid_in_c0,
    input  wire [9:0]  vid_in_c1,
    input  wire [9:0]  vid_in_c2,
    output reg         vid_out_valid,
    output reg  [9:0]  vid_out_c0,
    output reg  [9:0]  vid_out_c1,
    output reg  [9:0]  vid_out_c2,
    output reg  [31:0] tc_value_ff,
    output reg         drop_frame_ff,
    output reg         linear_tc_packet_enable,
    output reg         interval_tc_packet_enable,
    output reg         edh_insert_ff,
    output reg         audio_mute_ff,
    output reg         nonstandard_ff
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // automatic parity on the low byte
    function [9:0] par10;
        input [9:0] w;
        begin
            par10 = {~(^w[7:0]), ^w[7:0], w[7:0]};
        end
    endfunction

    // merge a write under byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[k*8 +: 8] = wd[k*8 +: 8];
                end
            end
        end
    endfunction

    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;
    localparam [27:0] ON_N  = ON_CYCLES[27:0];
    localparam [27:0] CYC_N = ON_N + OFF_CYCLES[27:0];

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_s1_ff;
    reg rst_s2_ff;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    wire rst_ok = rst_s2_ff;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [17:0] ctrl_ff;
    reg  [31:0] tc_offset_ff;
    reg  [9:0]  did_ff;
    reg  [9:0]  sdid_ff;
    reg  [9:0]  dc_ff;
    reg  [9:0]  cs_ff;
    reg  [31:0] lines_ff;
    reg  [11:0] sample_ff;
    reg  [7:0]  udw_idx_ff;
    reg  [9:0]  udw_ff [0:`UDW_DEPTH-1];
    reg         pend_ff;
    reg         state_ff;
    reg  [27:0] dly_cnt_ff;

    wire        acc  = ~avs_waitrequest & (avs_read | avs_write);
    wire        wr   = acc & avs_write;
    wire        trig = wr & (avs_address == `REG_CTRL) & avs_byteenable[2] & avs_writedata[`CTL_TRIG];
    wire [1:0]  mode = ctrl_ff[`CTL_MODE_LO +: 2];
    wire        man  = ctrl_ff[`CTL_MANUAL];
    wire [31:0] ctrl_w = merge({14'h0, ctrl_ff}, avs_writedata, avs_byteenable);

    // one wait cycle, then the answer at the edge where waitrequest is low
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    // software writes; storage always holds all 10 bits
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            ctrl_ff      <= `CTRL_RESET;
            tc_offset_ff <= 32'h0;
            did_ff       <= 10'h0;
            sdid_ff      <= 10'h0;
            dc_ff        <= 10'h0;
            cs_ff        <= 10'h0;
            lines_ff     <= 32'h0;
            sample_ff    <= 12'h0;
            udw_idx_ff   <= 8'h0;
        end else if (wr) begin
            case (avs_address)
                `REG_CTRL:      ctrl_ff      <= {1'b0, ctrl_w[16:0]};
                `REG_TC_OFFSET: tc_offset_ff <= merge(tc_offset_ff, avs_writedata, avs_byteenable);
                `REG_DID:       did_ff       <= avs_writedata[9:0];
                `REG_SDID:      sdid_ff      <= avs_writedata[9:0];
                `REG_DC:        dc_ff        <= avs_writedata[9:0];
                `REG_CS:        cs_ff        <= avs_writedata[9:0];
                `REG_LINES:     lines_ff     <= merge(lines_ff, avs_writedata, avs_byteenable);
                `REG_SAMPLE:    sample_ff    <= avs_writedata[11:0];
                `REG_UDW_INDEX: udw_idx_ff   <= avs_writedata[7:0];
                default:        ctrl_ff      <= ctrl_ff;
            endcase
        end
    end

    // user word store; index 255 is outside the store and is dropped
    integer i;
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            for (i = 0; i < `UDW_DEPTH; i = i + 1) begin
                udw_ff[i] <= 10'h0;
            end
        end else if (wr && avs_address == `REG_UDW_DATA && udw_idx_ff != 8'hff) begin
            udw_ff[udw_idx_ff] <= avs_writedata[9:0];
        end
    end

    // read mux, loaded as the request is first seen so data stand at the taken edge
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & avs_waitrequest) begin
            case (avs_address)
                `REG_CTRL:      avs_readdata <= {14'h0, ctrl_ff};
                `REG_TC_OFFSET: avs_readdata <= tc_offset_ff;
                `REG_DID:       avs_readdata <= {22'h0, did_ff};
                `REG_SDID:      avs_readdata <= {22'h0, sdid_ff};
                `REG_DC:        avs_readdata <= {22'h0, dc_ff};
                `REG_CS:        avs_readdata <= {22'h0, cs_ff};
                `REG_LINES:     avs_readdata <= lines_ff;
                `REG_SAMPLE:    avs_readdata <= {20'h0, sample_ff};
                `REG_UDW_INDEX: avs_readdata <= {24'h0, udw_idx_ff};
                `REG_UDW_DATA:  avs_readdata <= (udw_idx_ff == 8'hff) ? 32'h0 : {22'h0, udw_ff[udw_idx_ff]};
                `REG_STATUS:    avs_readdata <= {27'h0, audio_mute_ff, nonstandard_ff, state_ff, pend_ff,
                                                 gps_fitted};
                `REG_TC_VALUE:  avs_readdata <= tc_value_ff;
                default:        avs_readdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // timecode and simple enables
    // ----------------------------------------------------------------
    wire        use_tod = ctrl_ff[`CTL_TOD] & gps_fitted;
    wire [31:0] tc_src  = use_tod ? tod_tc : prog_tc;
    wire        comp_all = ctrl_ff[`CTL_COMP_Y] & ctrl_ff[`CTL_COMP_CB] & ctrl_ff[`CTL_COMP_CR];

    // the offset is a plain binary frame offset, applied every clock
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            tc_value_ff               <= 32'h0;
            drop_frame_ff             <= 1'b0;
            linear_tc_packet_enable   <= 1'b0;
            interval_tc_packet_enable <= 1'b0;
            edh_insert_ff             <= 1'b0;
            nonstandard_ff            <= 1'b0;
        end else begin
            tc_value_ff               <= tc_src + tc_offset_ff;
            drop_frame_ff             <= ctrl_ff[`CTL_DROP] & fmt_fractional;
            linear_tc_packet_enable   <= ctrl_ff[`CTL_LTC];
            interval_tc_packet_enable <= ctrl_ff[`CTL_VITC];
            edh_insert_ff             <= ctrl_ff[`CTL_EDH] & fmt_sd;
            nonstandard_ff            <= ~comp_all | ~ctrl_ff[`CTL_EDGE] | ctrl_ff[`CTL_DELAY];
        end
    end

    // ----------------------------------------------------------------
    // delay test cycle
    // ----------------------------------------------------------------
    // counter restarts at zero whenever the mode is off, so each run opens lit
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            dly_cnt_ff    <= 28'h0;
            audio_mute_ff <= 1'b0;
        end else if (!ctrl_ff[`CTL_DELAY]) begin
            dly_cnt_ff    <= 28'h0;
            audio_mute_ff <= 1'b0;
        end else begin
            dly_cnt_ff    <= (dly_cnt_ff == CYC_N - 28'h1) ? 28'h0 : dly_cnt_ff + 28'h1;
            audio_mute_ff <= (dly_cnt_ff >= ON_N - 28'h1) && (dly_cnt_ff != CYC_N - 28'h1);
        end
    end
    wire black = audio_mute_ff;

    // ----------------------------------------------------------------
    // packet placement
    // ----------------------------------------------------------------
    reg  [11:0] samp_ff;
    reg  [8:0]  pos_ff;
    reg  [8:0]  sum_ff;
    reg         sav_seen_ff;
    wire [1:0]  fsel = ctrl_ff[`CTL_FIELD_LO +: 2];
    wire [10:0] tgt_line = vid_in_field2 ? lines_ff[26:16] : lines_ff[10:0];
    wire        fld_ok = vid_in_field2 ? fsel[1] : fsel[0];
    wire        in_rng = (tgt_line <= line_max) && (sample_ff <= sample_max);
    wire        armed  = (mode == `MODE_CONT) | ((mode == `MODE_SINGLE) & pend_ff);
    wire        hit    = vid_in_valid & sav_seen_ff & (vid_in_line == tgt_line) & (samp_ff == sample_ff);
    wire        start  = (state_ff == ST_IDLE) & armed & in_rng & fld_ok & hit & ~vid_in_protect;
    wire [8:0]  ucnt   = {1'b0, dc_ff[7:0]};
    wire [8:0]  last   = ucnt + 9'h3;
    wire        step   = vid_in_valid & ~vid_in_protect;

    // word at a packet position, before parity
    reg  [9:0]  raw_w;
    reg  [7:0]  ui;
    always @* begin
        ui = pos_ff[7:0] - 8'h3;
        if (pos_ff == 9'h0) begin
            raw_w = did_ff;
        end else if (pos_ff == 9'h1) begin
            raw_w = sdid_ff;
        end else if (pos_ff == 9'h2) begin
            raw_w = dc_ff;
        end else if (pos_ff == last) begin
            raw_w = cs_ff;
        end else if (ui == 8'hff) begin
            raw_w = 10'h0;
        end else begin
            raw_w = udw_ff[ui];
        end
    end

    wire        is_cs  = (pos_ff == last);
    wire [9:0]  par_w  = man ? raw_w : par10(raw_w);
    wire [8:0]  sum_n  = sum_ff + par_w[8:0];
    wire [9:0]  cs_gen = {~sum_ff[8], sum_ff};
    wire [9:0]  pkt_w  = is_cs ? (ctrl_ff[`CTL_CS_AUTO] ? cs_gen : par_w) : par_w;

    // sample counter from sav; header goes out at the chosen sample
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            samp_ff     <= 12'h0;
            sav_seen_ff <= 1'b0;
        end else if (vid_in_sav) begin
            samp_ff     <= 12'h0;
            sav_seen_ff <= 1'b1;
        end else if (vid_in_valid && samp_ff != 12'hfff) begin
            samp_ff     <= samp_ff + 12'h1;
        end
    end

    // sequencer; a protected word pauses it so the packet slides past
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            state_ff <= ST_IDLE;
            pos_ff   <= 9'h0;
            sum_ff   <= 9'h0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    pos_ff <= 9'h0;
                    sum_ff <= 9'h0;
                    if (start) begin
                        state_ff <= ST_SEND;
                        pos_ff   <= 9'h1;
                        sum_ff   <= par_w[8:0];
                    end
                end
                ST_SEND: begin
                    if (mode == `MODE_OFF) begin
                        state_ff <= ST_IDLE;
                    end else if (step) begin
                        if (is_cs) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            pos_ff <= pos_ff + 9'h1;
                            sum_ff <= sum_n;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // single-shot request; a new trigger beats the clear of the same cycle
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            pend_ff <= 1'b0;
        end else if (trig) begin
            pend_ff <= 1'b1;
        end else if (start || mode != `MODE_SINGLE) begin
            pend_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // video path
    // ----------------------------------------------------------------
    reg  [9:0] prev0_ff;
    reg  [9:0] prev1_ff;
    reg  [9:0] prev2_ff;
    wire       filt  = ctrl_ff[`CTL_EDGE] & filter_fitted & vid_in_active;
    wire       put   = (start | (state_ff == ST_SEND)) & step;
    wire       kill  = vid_in_active & black;
    wire       chrom = ctrl_ff[`CTL_CHROMA];

    // gate a component then optionally smooth its edges by a mean with the previous result
    function [9:0] shape;
        input [9:0] cur;
        input [9:0] prv;
        input       en;
        input       blk;
        input [9:0] lvl;
        input       f;
        reg   [10:0] s;
        reg   [9:0]  g;
        begin
            g = (en & ~blk) ? cur : lvl;
            s = {1'b0, g} + {1'b0, prv};
            shape = f ? s[10:1] : g;
        end
    endfunction

    wire [9:0] g0 = shape(vid_in_c0, prev0_ff, ctrl_ff[`CTL_COMP_Y] | ~vid_in_active, kill,
                          `BLANK_LUMA, filt);
    wire [9:0] g1 = shape(vid_in_c1, prev1_ff, ctrl_ff[`CTL_COMP_CB] | ~vid_in_active, kill,
                          `BLANK_CHROMA, filt);
    wire [9:0] g2 = shape(vid_in_c2, prev2_ff, ctrl_ff[`CTL_COMP_CR] | ~vid_in_active, kill,
                          `BLANK_CHROMA, filt);

    // packet words replace the chosen channel; audio and crc pass untouched
    always @(posedge core_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            vid_out_valid <= 1'b0;
            vid_out_c0    <= 10'h0;
            vid_out_c1    <= 10'h0;
            vid_out_c2    <= 10'h0;
            prev0_ff      <= 10'h0;
            prev1_ff      <= 10'h0;
            prev2_ff      <= 10'h0;
        end else begin
            vid_out_valid <= vid_in_valid;
            if (vid_in_valid) begin
                prev0_ff   <= g0;
                prev1_ff   <= g1;
                prev2_ff   <= g2;
                vid_out_c0 <= (put & ~chrom) ? pkt_w : g0;
                vid_out_c1 <= (put & chrom) ? pkt_w : g1;
                vid_out_c2 <= g2;
            end
        end
    end
endmodule // anc_tc_inserter

// ==== common/anc_tc_map.vh ====
/*
 * register offsets, field positions, reset values and timing counts
 * of the ancillary timecode and user packet inserter.
 * assumes word addressing on the avalon slave; byte address = 4 * index.
 */
`ifndef ANC_TC_MAP_VH
`define ANC_TC_MAP_VH
// ----------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------
`define REG_CTRL       4'h0
`define REG_TC_OFFSET  4'h1
`define REG_DID        4'h2
`define REG_SDID       4'h3
`define REG_DC         4'h4
`define REG_CS         4'h5
`define REG_LINES      4'h6
`define REG_SAMPLE     4'h7
`define REG_UDW_INDEX  4'h8
`define REG_UDW_DATA   4'h9
`define REG_STATUS     4'ha
`define REG_TC_VALUE   4'hb
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTL_TOD        0
`define CTL_DROP       1
`define CTL_LTC        2
`define CTL_VITC       3
`define CTL_COMP_Y     4
`define CTL_COMP_CB    5
`define CTL_COMP_CR    6
`define CTL_EDGE       7
`define CTL_DELAY      8
`define CTL_EDH        9
`define CTL_MODE_LO    10
`define CTL_MANUAL     12
`define CTL_CS_AUTO    13
`define CTL_FIELD_LO   14
`define CTL_CHROMA     16
`define CTL_TRIG       17
`define CTRL_RESET     18'h0e0f0
`define CTRL_WMASK     32'h0001ffff
// ----------------------------------------------------------------
// modes and levels
// ----------------------------------------------------------------
`define MODE_OFF       2'h0
`define MODE_CONT      2'h1
`define MODE_SINGLE    2'h2
`define BLANK_LUMA     10'h040
`define BLANK_CHROMA   10'h200
`define UDW_DEPTH      255
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ         10000000
`define ON_TIME_S      1
`define OFF_TIME_S     4
`define ON_CYCLES      (`ON_TIME_S * `CLK_HZ)
`define OFF_CYCLES     (`OFF_TIME_S * `CLK_HZ)
`endif

// ==== verif/anc_tc_asserts.sv ====
/* port assertions for anc_tc_inserter, bound to every instance.
 * assumes the delay-test off count is handed on by the bind. */
`timescale 1ns/1ps
module anc_tc_asserts #(parameter OFF_CYCLES = 16) (
    input wire       core_clk, rst_n, avs_read, avs_write, avs_waitrequest, vid_in_valid,
    input wire       vid_in_active, vid_in_protect, fmt_fractional, fmt_sd, vid_out_valid,
    input wire       drop_frame_ff, edh_insert_ff, audio_mute_ff, nonstandard_ff,
    input wire [9:0] vid_in_c0, vid_in_c1, vid_out_c0, vid_out_c1
);
    reg [31:0] mute_cnt_ff;
    // length of the current mute stretch; a counter keeps the property cheap
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n) mute_cnt_ff <= 32'h0;
        else mute_cnt_ff <= audio_mute_ff ? mute_cnt_ff + 32'h1 : 32'h0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    word_pass_a: assert property (vid_out_valid == $past(vid_in_valid))
        else $error("output strobe not one cycle behind input");
    protect_pass_a: assert property (vid_in_valid && vid_in_protect && !vid_in_active |=>
        vid_out_c0 == $past(vid_in_c0) && vid_out_c1 == $past(vid_in_c1)) else $error("protected word altered");
    drop_rate_a: assert property (drop_frame_ff |-> $past(fmt_fractional))
        else $error("drop frame at an integer rate");
    edh_sd_a: assert property (edh_insert_ff |-> $past(fmt_sd))
        else $error("edh insertion outside standard definition");
    mute_flag_a: assert property ($rose(audio_mute_ff) |-> nonstandard_ff)
        else $error("mute without nonstandard marker");
    mute_len_a: assert property (audio_mute_ff |-> mute_cnt_ff < OFF_CYCLES)
        else $error("mute stretch too long");
    cover property ($rose(audio_mute_ff));
    cover property (vid_in_valid && vid_in_protect);
    cover property (avs_read && !avs_waitrequest);
endmodule // anc_tc_asserts
bind anc_tc_inserter anc_tc_asserts #(.OFF_CYCLES(OFF_CYCLES)) u_asserts (.core_clk, .rst_n, .avs_read,
    .avs_write, .avs_waitrequest, .vid_in_valid, .vid_in_active, .vid_in_protect, .fmt_fractional, .fmt_sd,
    .vid_out_valid, .drop_frame_ff, .edh_insert_ff, .audio_mute_ff, .nonstandard_ff, .vid_in_c0,
    .vid_in_c1, .vid_out_c0, .vid_out_c1);

// ==== verif/video_sink.sv ====
/* downstream receiver model: logs the luma channel of each line by sample.
 * assumes output words trail the input raster by one clock. */
`timescale 1ns/1ps
module video_sink (
    input wire       core_clk,
    input wire       vid_in_sav,
    input wire       vid_out_valid,
    input wire [9:0] vid_out_c0
);
    reg       sav_d = 1'h0;
    reg [3:0] idx   = 4'h0;
    reg [9:0] cap [0:15];
    // sav seen one clock late lines up with output sample 0
    always @(posedge core_clk) begin
        sav_d <= vid_in_sav;
        if (sav_d)
            idx <= 4'h0;
        else if (vid_out_valid) begin
            cap[idx] <= vid_out_c0;
            idx      <= idx + 4'h1;
        end
    end
endmodule // video_sink

// ==== verif/test_anc_tc_inserter.sv ====
/* self-checking bench for anc_tc_inserter with a receiver model.
 * assumes 10 MHz clock and delay-test counts of 4 on, 16 off. */
`timescale 1ns/1ps
module test_anc_tc_inserter;
    localparam [49:0] DV = {10'h000, 10'h3c1, 10'h002, 10'h005, 10'h2a5};
    reg         core_clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, fit = 1'h1, frac = 1'h0;
    reg         sd = 1'h1, flt = 1'h1, vv = 1'h0, sav = 1'h0, act = 1'h0, prot = 1'h0;
    reg  [3:0]  adr = 4'h0;
    reg  [9:0]  c0 = 10'h0, c1 = 10'h150, s, v, e [0:13], pw [0:5];
    reg  [31:0] wd = 32'h0, q, ptc = 32'h100, ttc = 32'h2000;
    reg  [11:0] smax = 12'h14;
    wire [31:0] rdat, tcv;
    wire [9:0]  o0, o1, o2;
    wire        wt, ov, dfr, ltc, vtc, edh, mute, nstd;
    integer     errors = 0, total_checks = 0, i, n;
    always #50 core_clk = ~core_clk;
    anc_tc_inserter #(.ON_CYCLES(4), .OFF_CYCLES(16)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata(rdat), .avs_waitrequest(wt), .prog_tc(ptc), .tod_tc(ttc), .gps_fitted(fit),
        .fmt_fractional(frac), .fmt_sd(sd), .filter_fitted(flt), .line_max(11'h64), .sample_max(smax),
        .vid_in_valid(vv), .vid_in_sav(sav), .vid_in_active(act), .vid_in_field2(1'h0),
        .vid_in_line(11'ha), .vid_in_protect(prot), .vid_in_c0(c0), .vid_in_c1(c1), .vid_in_c2(10'h3ff),
        .vid_out_valid(ov), .vid_out_c0(o0), .vid_out_c1(o1), .vid_out_c2(o2), .tc_value_ff(tcv),
        .drop_frame_ff(dfr), .linear_tc_packet_enable(ltc), .interval_tc_packet_enable(vtc),
        .edh_insert_ff(edh), .audio_mute_ff(mute), .nonstandard_ff(nstd));
    video_sink i_sink (.core_clk(core_clk), .vid_in_sav(sav), .vid_out_valid(ov), .vid_out_c0(o0));
    task chk(input [31:0] got, input [31:0] exp); begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end endtask
    // one avalon transfer; request held until waitrequest is seen low
    task bus(input w, input [3:0] a, input [31:0] d); begin
        rd <= !w; wr <= w; adr <= a; wd <= d;
        @(posedge core_clk);
        while (wt !== 1'h0) @(posedge core_clk);
        q = rdat; rd <= 1'h0; wr <= 1'h0;
        @(posedge core_clk);
    end endtask
    function [9:0] ap(input [9:0] x); ap = {~^x[7:0], ^x[7:0], x[7:0]}; endfunction
    // expected packet words for manual or auto parity and checksum
    task expw(input man, input csa); begin
        s = 10'h0;
        for (i = 0; i < 5; i = i + 1) begin v = DV[i*10 +: 10]; pw[i] = man ? v : ap(v); s = s + pw[i]; end
        pw[5] = csa ? {~s[8], s[8:0]} : ap(10'h07b);
    end endtask
    // one blanking line of 14 words, word 5 protected, packet at sample 3
    task vline(input on); begin
        sav <= 1'h1; @(posedge core_clk); sav <= 1'h0; vv <= 1'h1;
        for (i = 0; i < 14; i = i + 1) begin
            c0 <= 10'h100 + i; prot <= (i == 5); e[i] = 10'h100 + i; @(posedge core_clk);
        end
        vv <= 1'h0; prot <= 1'h0; repeat (2) @(posedge core_clk);
        if (on) begin e[3] = pw[0]; e[4] = pw[1]; e[6] = pw[2]; e[7] = pw[3]; e[8] = pw[4]; e[9] = pw[5]; end
        for (i = 0; i < 14; i = i + 1) chk(i_sink.cap[i], e[i]);
    end endtask
    task step(input [9:0] x0, input [9:0] x1); begin
        c1 <= 10'h100; @(posedge core_clk); c1 <= 10'h300; repeat (2) @(posedge core_clk);
        chk({o0, o1}, {x0, x1});
    end endtask
    task tally_and_finish; begin
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1; repeat (3) @(posedge core_clk);
        bus(0, 0, 0); chk(q, 32'he0f0);
        bus(0, 12, 0); chk(q, 32'h0);
        bus(1, 8, 32'hfe); bus(1, 9, 32'h3c1); bus(0, 9, 0); chk(q, 32'h3c1);
        bus(1, 8, 32'hff); bus(1, 9, 32'h155); bus(0, 9, 0); chk(q, 32'h0);
        $display("register test done");
        bus(1, 1, 32'h10); bus(1, 0, 32'he2f7); repeat (2) @(posedge core_clk);
        chk(tcv, ttc + 32'h10); chk({dfr, ltc, vtc, edh}, 4'h5);
        fit <= 1'h0; frac <= 1'h1; sd <= 1'h0; bus(1, 0, 32'he2fb); repeat (2) @(posedge core_clk);
        chk(tcv, ptc + 32'h10); chk({dfr, ltc, vtc, edh}, 4'ha);
        bus(1, 0, 32'he0f0); fit <= 1'h1; frac <= 1'h0; sd <= 1'h1;
        $display("timecode test done");
        act <= 1'h1; vv <= 1'h1; c0 <= 10'h2a0;
        bus(1, 0, 32'he060); step(10'h040, 10'h300); chk(nstd, 1);
        flt <= 1'h0; bus(1, 0, 32'he0f0); step(10'h2a0, 10'h300); chk(nstd, 0);
        flt <= 1'h1; step(10'h2a0, 10'h280); flt <= 1'h0;
        bus(1, 0, 32'he090); step(10'h2a0, 10'h200); chk(o2, 10'h200);
        act <= 1'h0; vv <= 1'h0; flt <= 1'h1;
        $display("video test done");
        bus(1, 0, 32'he1f0); n = 0;
        while (mute !== 1'h1 && n < 99) begin @(posedge core_clk); n = n + 1; end
        n = 0; while (mute === 1'h1 && n < 99) begin @(posedge core_clk); n = n + 1; end
        chk(n, 16); chk(nstd, 1);
        n = 0; while (mute !== 1'h1 && n < 99) begin @(posedge core_clk); n = n + 1; end
        chk(n, 4);
        bus(1, 0, 32'he0f0);
        $display("delay test done");
        bus(1, 2, 32'h2a5); bus(1, 3, 32'h5); bus(1, 4, 32'h2); bus(1, 5, 32'h7b); bus(1, 6, 32'ha000a);
        bus(1, 7, 32'h3); bus(1, 8, 32'h0); bus(1, 9, 32'h3c1); bus(1, 8, 32'h1); bus(1, 9, 32'h0);
        bus(1, 0, 32'he4f0); expw(0, 1); vline(1);
        bus(1, 0, 32'hf4f0); expw(1, 1); vline(1);
        bus(1, 0, 32'hc4f0); expw(0, 0); vline(1);
        bus(1, 0, 32'he8f0); bus(1, 0, 32'h2e8f0); expw(0, 1); vline(1); vline(0);
        bus(1, 0, 32'he0f0); vline(0);
        bus(1, 0, 32'h1e4f0); vline(0);
        bus(1, 0, 32'he4f0); smax <= 12'h2; vline(0);
        $display("packet test done");
        tally_and_finish;
    end
    initial begin
        #1000000;
        errors = errors + 1;
        tally_and_finish;
    end
endmodule // test_anc_tc_inserter
